// File: rtl/bpm_ctrl.sv
// Mode, charger, button and level indicator controller with an AHB-Lite register slave.
// What this block does
// - Output undervoltage while limiting: hiccup input switch 2s.
// - Charge mode: input switch on, buck converter.
// - Boost mode: step-up, input off, reverse blocked.
// - High-impedance mode: all four switches off.
// - Charge/boost changes pass 2s all-off gap.
// - Valid input supply always selects charge mode.
// - No supply: select 0 boost, 1 HZ.
// - Button held past 100ms (30ms) enables boost.
// - Flashlight variant: 3s hold toggles flashlight.
// - Each charge cycle starts in precondition state.
// - Precondition uses 10 percent current reference.
// - Fast charge full current until termination voltage.
// - Top-off constant voltage until current below 13%.
// - End of charge stops charging, keeps monitoring.
// - Recharge when battery drops 200mV below EOC.
// - LED states follow battery level and mode.
// - Low battery flashes first LED; full: all on.
// - Four ordered level thresholds compared against battery.
// - Thresholds shift while charging or discharging.
// - Charge: passed first to third levels on, next flashes.
// - Flashing is 1s on, 1s off.
// - After button release show levels about 5s.
//
// The register offsets and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/10ps
module bpm_ctrl
  import bpm_pkg::*;
#(
  parameter int unsigned TICK_CYCLES   = TICK_CYC,
  parameter int unsigned HICCUP_TICKS  = HICCUP_MS,
  parameter int unsigned TRAN_TICKS    = TRAN_MS,
  parameter int unsigned PB_BOOST_TK   = PB_BOOST_MS,
  parameter int unsigned PB_BOOST_FL_TK = PB_BOOST_FL_MS,
  parameter int unsigned PB_FLASH_TK   = PB_FLASH_MS,
  parameter int unsigned LED_SHOW_TK   = LED_SHOW_MS,
  parameter int unsigned LED_BLINK_TK  = LED_BLINK_MS
) (
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                rst,
  // AHB-Lite slave
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic                     hreadyout,
  output logic                     hresp,
  output logic      [31:0]         hrdata,
  // Analog front end
  input  wire bpm_sense_t          sense,
  output bpm_switch_t              switches,
  output bpm_cur_t                 charge_current_set,
  output logic      [1:0]          level_threshold_shift,
  // Indicators
  output logic                     level_indicator_first,
  output logic                     level_indicator_second,
  output logic                     level_indicator_third,
  output logic                     level_indicator_fourth,
  output logic                     flashlight_on
);

  bpm_sense_t        sense_s;
  bpm_mode_t         mode;
  bpm_chg_t          chg;
  logic [TICK_W-1:0] tick_cnt;
  logic [TMR_W-1:0]  gap_cnt, hic_cnt, pb_cnt, show_cnt, blink_cnt, boost_thr;
  logic              tick, blink, wr_pend, variant, pressed, boost_hold;
  logic [31:0]       ctrl, status;
  logic [ADDR_W-1:0] wr_addr;
  logic [3:0]        lvl, leds, next_leds;
  bpm_switch_t       next_switches;
  bpm_cur_t          next_cur;

  bpm_sync #(.WIDTH($bits(bpm_sense_t))) u_sync (
    .sys_clk (sys_clk), .rst (rst), .din (sense), .dout (sense_s)
  );
  // One millisecond enable from the system clock.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end else if (tick_cnt == TICK_W'(TICK_CYCLES - 1)) begin
      tick_cnt <= '0;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
      tick     <= 1'b0;
    end
  end

  assign variant    = ctrl[CTRL_FLASH_VARIANT];
  assign pressed    = ~sense_s.push_button_input_n;
  assign boost_thr  = variant ? TMR_W'(PB_BOOST_FL_TK) : TMR_W'(PB_BOOST_TK);
  assign boost_hold = pressed && (pb_cnt > boost_thr);

  // Button hold timer, saturating at the flashlight hold time.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pb_cnt <= '0;
    end else if (!pressed) begin
      pb_cnt <= '0;
    end else if (tick && pb_cnt != TMR_W'(PB_FLASH_TK)) begin
      pb_cnt <= pb_cnt + 1'b1;
    end
  end

  // The toggle fires once per hold, when the counter reaches the hold time.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      flashlight_on <= 1'b0;
    end else if (!variant) begin
      flashlight_on <= 1'b0;
    end else if (pressed && tick && pb_cnt == TMR_W'(PB_FLASH_TK - 1)) begin
      flashlight_on <= ~flashlight_on;
    end
  end

  // Operating mode selection with the all-off gap between active modes.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mode    <= BPM_MODE_HZ;
      gap_cnt <= '0;
    end else begin
      case (mode)
        BPM_MODE_HZ: begin
          if (gap_cnt != '0) begin
            if (tick) begin
              gap_cnt <= gap_cnt - 1'b1;
            end
          end else if (sense_s.input_supply_valid) begin
            mode <= BPM_MODE_CHARGE;
          end else if (!sense_s.storage_select && boost_hold) begin
            mode <= BPM_MODE_BOOST;
          end
        end
        BPM_MODE_CHARGE: begin
          if (!sense_s.input_supply_valid) begin
            mode    <= BPM_MODE_HZ;
            gap_cnt <= TMR_W'(TRAN_TICKS);
          end
        end
        BPM_MODE_BOOST: begin
          if (sense_s.input_supply_valid || sense_s.storage_select) begin
            mode    <= BPM_MODE_HZ;
            gap_cnt <= TMR_W'(TRAN_TICKS);
          end
        end
        default: begin
          mode    <= BPM_MODE_HZ;
          gap_cnt <= '0;
        end
      endcase
    end
  end

  // Hiccup restart of the input path after an output undervoltage.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hic_cnt <= '0;
    end else if (mode != BPM_MODE_CHARGE) begin
      hic_cnt <= '0;
    end else if (hic_cnt != '0) begin
      if (tick) begin
        hic_cnt <= hic_cnt - 1'b1;
      end
    end else if (switches.input_path_switch && sense_s.out_below_uvp &&
                 sense_s.input_path_limiting) begin
      hic_cnt <= TMR_W'(HICCUP_TICKS);
    end
  end

  // Charger state sequence; it falls back to idle whenever charge mode ends.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      chg <= BPM_CHG_IDLE;
    end else if (mode != BPM_MODE_CHARGE) begin
      chg <= BPM_CHG_IDLE;
    end else begin
      case (chg)
        BPM_CHG_IDLE: chg <= BPM_CHG_PRE;
        BPM_CHG_PRE:    if (sense_s.bat_above_precond) chg <= BPM_CHG_FAST;
        BPM_CHG_FAST:   if (sense_s.bat_at_term) chg <= BPM_CHG_TOPOFF;
        BPM_CHG_TOPOFF: if (sense_s.chg_below_eoc) chg <= BPM_CHG_EOC;
        BPM_CHG_EOC:    if (sense_s.bat_below_recharge) chg <= BPM_CHG_FAST;
        default: chg <= BPM_CHG_IDLE;
      endcase
    end
  end

  // Switch and current reference decode; the converter idles in end of charge.
  always_comb begin
    next_switches = '0;
    next_cur      = BPM_CUR_OFF;
    case (mode)
      BPM_MODE_CHARGE: begin
        next_switches.input_path_switch = (hic_cnt == '0);
        if (chg != BPM_CHG_IDLE && chg != BPM_CHG_EOC) begin
          next_switches.converter_high_switch = 1'b1;
          next_switches.converter_low_switch  = 1'b1;
        end
        case (chg)
          BPM_CHG_PRE:    next_cur = BPM_CUR_PRE;
          BPM_CHG_FAST:   next_cur = BPM_CUR_FULL;
          BPM_CHG_TOPOFF: next_cur = BPM_CUR_CV;
          default:        next_cur = BPM_CUR_OFF;
        endcase
      end
      BPM_MODE_BOOST: begin
        next_switches.converter_high_switch = 1'b1;
        next_switches.converter_low_switch  = 1'b1;
        next_switches.input_reverse_block   = 1'b1;
      end
      default: next_switches = '0;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      switches              <= '0;
      charge_current_set    <= BPM_CUR_OFF;
      level_threshold_shift <= SHIFT_NONE;
    end else begin
      switches              <= next_switches;
      charge_current_set    <= next_cur;
      level_threshold_shift <= (mode == BPM_MODE_CHARGE) ? SHIFT_CHARGE :
                               (mode == BPM_MODE_BOOST)  ? SHIFT_DISCHG : SHIFT_NONE;
    end
  end

  // Flash phase and level display window.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      blink_cnt <= '0;
      blink     <= 1'b0;
    end else if (tick) begin
      if (blink_cnt == TMR_W'(LED_BLINK_TK - 1)) begin
        blink_cnt <= '0;
        blink     <= ~blink;
      end else begin
        blink_cnt <= blink_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      show_cnt <= '0;
    end else if (boost_hold) begin
      show_cnt <= TMR_W'(LED_SHOW_TK);
    end else if (tick && !pressed && show_cnt != '0) begin
      show_cnt <= show_cnt - 1'b1;
    end
  end

  // A comparator set out of order is cleaned to a thermometer code.
  assign lvl = {&sense_s.bat_above_level[3:0], &sense_s.bat_above_level[2:0],
                &sense_s.bat_above_level[1:0], sense_s.bat_above_level[0]};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_led
      logic below_ok;
      logic passed;
      assign below_ok = (gi == 0) ? 1'b1 : lvl[(gi == 0) ? 0 : gi - 1];
      assign passed   = (gi == 3) ? 1'b0 : lvl[gi];
      always_comb begin
        if (mode == BPM_MODE_CHARGE) begin
          next_leds[gi] = (chg == BPM_CHG_EOC) || (below_ok && (passed || blink));
        end else if (show_cnt != '0) begin
          next_leds[gi] = lvl[gi] || (gi == 0 && blink);
        end else begin
          next_leds[gi] = 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      leds <= '0;
    end else begin
      leds <= next_leds;
    end
  end

  assign {level_indicator_fourth, level_indicator_third,
          level_indicator_second, level_indicator_first} = leds;
  // AHB-Lite slave: zero wait states, always OKAY, read data captured in the address phase.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_comb begin
    status = '0;
    status[ST_MODE_LSB +: 2] = mode;
    status[ST_CHG_LSB +: 3]  = chg;
    status[ST_LED_LSB +: 4]  = leds;
    status[ST_FLASHLIGHT]    = flashlight_on;
    status[ST_HICCUP]        = (hic_cnt != '0);
    status[ST_GAP]           = (gap_cnt != '0);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
      hrdata  <= '0;
    end else begin
      wr_pend <= hsel && htrans[1] && hready && hwrite;
      wr_addr <= haddr[ADDR_W-1:0];
      if (hsel && htrans[1] && hready && !hwrite) begin
        case (haddr[ADDR_W-1:0])
          REG_CTRL:   hrdata <= ctrl;
          REG_STATUS: hrdata <= status;
          default:    hrdata <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl <= CTRL_RESET;
    end else if (wr_pend && wr_addr == REG_CTRL) begin
      ctrl <= {31'h0000_0000, hwdata[CTRL_FLASH_VARIANT]};
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  hiccup_start_a: assert property (mode == BPM_MODE_CHARGE && hic_cnt == '0 &&
      switches.input_path_switch && sense_s.out_below_uvp && sense_s.input_path_limiting
      |=> hic_cnt == TMR_W'(HICCUP_TICKS) ##1 !switches.input_path_switch)
    else $error("Hiccup did not turn the input path off.");
  charge_path_a: assert property (mode == BPM_MODE_CHARGE && $stable(mode)
      && hic_cnt == '0 |=> switches.input_path_switch)
    else $error("Input path not enabled in charge mode.");
  boost_path_a: assert property (mode == BPM_MODE_BOOST |=>
      !switches.input_path_switch && switches.input_reverse_block && switches.converter_low_switch)
    else $error("Boost mode switch pattern wrong.");
  hz_all_off_a: assert property (mode == BPM_MODE_HZ |=> switches == '0)
    else $error("A switch is on in high-impedance mode.");
  mode_gap_a: assert property ($changed(mode) && $past(mode) != BPM_MODE_HZ
      |-> gap_cnt == TMR_W'(TRAN_TICKS) && mode == BPM_MODE_HZ)
    else $error("Leaving an active mode did not arm the gap.");
  supply_charge_a: assert property (mode == BPM_MODE_HZ && gap_cnt == '0 &&
      sense_s.input_supply_valid |=> mode == BPM_MODE_CHARGE)
    else $error("Valid supply did not select charge mode.");
  storage_hz_a: assert property (sense_s.storage_select && !sense_s.input_supply_valid
      |=> mode != BPM_MODE_BOOST || $past(mode) == BPM_MODE_HZ)
    else $error("Boost kept with storage select high.");
  charge_start_a: assert property (mode == BPM_MODE_CHARGE && chg == BPM_CHG_IDLE
      |=> chg == BPM_CHG_PRE ##1 charge_current_set == BPM_CUR_PRE)
    else $error("Charge cycle did not start in precondition.");
  recharge_a: assert property (mode == BPM_MODE_CHARGE && chg == BPM_CHG_EOC &&
      sense_s.bat_below_recharge && sense_s.input_supply_valid |=> chg == BPM_CHG_FAST)
    else $error("Recharge did not restart fast charge.");
  full_leds_a: assert property (mode == BPM_MODE_CHARGE && chg == BPM_CHG_EOC
      |=> leds == 4'hF)
    else $error("End of charge did not light all indicators.");

endmodule : bpm_ctrl

// File: rtl/bpm_pkg.sv
// Constants, state encodings and signal bundles of the battery pack mode and charge controller.
package bpm_pkg;

  // Clock and timer base: one tick enable per millisecond.
  localparam int unsigned SYS_CLK_HZ     = 10_000_000;
  localparam int unsigned TICK_US        = 1000;
  localparam int unsigned TICK_CYC       = SYS_CLK_HZ / 1_000_000 * TICK_US;

  // Intervals in milliseconds, counted in ticks.
  localparam int unsigned HICCUP_MS      = 2000;
  localparam int unsigned TRAN_MS        = 2000;
  localparam int unsigned PB_BOOST_MS    = 100;
  localparam int unsigned PB_BOOST_FL_MS = 30;
  localparam int unsigned PB_FLASH_MS    = 3000;
  localparam int unsigned LED_SHOW_MS    = 5000;
  localparam int unsigned LED_BLINK_MS   = 1000;
  localparam int unsigned TMR_W          = 16;
  localparam int unsigned TICK_W         = 16;

  // Register map, byte addresses within the slave window.
  localparam int unsigned ADDR_W         = 8;
  localparam logic [7:0]  REG_CTRL       = 8'h00;
  localparam logic [7:0]  REG_STATUS     = 8'h04;
  localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;

  // Control register fields.
  localparam int unsigned CTRL_FLASH_VARIANT = 0;

  // Status register field positions.
  localparam int unsigned ST_MODE_LSB    = 0;
  localparam int unsigned ST_CHG_LSB     = 4;
  localparam int unsigned ST_LED_LSB     = 8;
  localparam int unsigned ST_FLASHLIGHT  = 12;
  localparam int unsigned ST_HICCUP      = 13;
  localparam int unsigned ST_GAP         = 14;

  // Threshold shift selection driven to the level comparators.
  localparam logic [1:0]  SHIFT_NONE     = 2'h0;
  localparam logic [1:0]  SHIFT_CHARGE   = 2'h1;
  localparam logic [1:0]  SHIFT_DISCHG   = 2'h2;

  typedef enum logic [1:0] {
    BPM_MODE_HZ,
    BPM_MODE_CHARGE,
    BPM_MODE_BOOST
  } bpm_mode_t;

  typedef enum logic [2:0] {
    BPM_CHG_IDLE,
    BPM_CHG_PRE,
    BPM_CHG_FAST,
    BPM_CHG_TOPOFF,
    BPM_CHG_EOC
  } bpm_chg_t;

  // Charge current reference: off, 10 percent, full constant current, constant voltage.
  typedef enum logic [1:0] {
    BPM_CUR_OFF,
    BPM_CUR_PRE,
    BPM_CUR_FULL,
    BPM_CUR_CV
  } bpm_cur_t;

  // Comparator and pin levels from the analog front end.
  typedef struct packed {
    logic       input_supply_valid;
    logic       storage_select;
    logic       push_button_input_n;
    logic       out_below_uvp;
    logic       input_path_limiting;
    logic       bat_above_precond;
    logic       bat_at_term;
    logic       chg_below_eoc;
    logic       bat_below_recharge;
    logic [3:0] bat_above_level;
  } bpm_sense_t;

  typedef struct packed {
    logic input_path_switch;
    logic converter_high_switch;
    logic converter_low_switch;
    logic input_reverse_block;
  } bpm_switch_t;

endpackage : bpm_pkg

// File: rtl/bpm_sync.sv
// Two-flop synchroniser for a bundle of asynchronous levels.
`timescale 1ns/10ps
module bpm_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // Levels
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] stage1;

  // The first stage feeds only the second one, to keep metastability contained.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stage1 <= '0;
      dout   <= '0;
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end

endmodule : bpm_sync

// File: sim/bpm_partner.sv
// Behavioural model of the supply, the cell and the push button in front of the controller.
`timescale 1ns/10ps
module bpm_partner
  import bpm_pkg::*;
(
  // Knobs set by the bench
  input  wire logic        supply_on,
  input  wire logic        store_sel,
  input  wire logic        pressed,
  input  wire logic        overload,
  input  wire logic        taper,
  input  wire logic [12:0] bat_mv,
  // Controller side
  input  wire bpm_switch_t switches,
  output bpm_sense_t       sense
);
  logic limiting;

  // The output only sags while the input path really carries the overload.
  assign limiting = overload & switches.input_path_switch;

  always_comb begin
    sense.input_supply_valid  = supply_on;
    sense.storage_select      = store_sel;
    // The button line has a pull-up, so a released button reads high.
    sense.push_button_input_n = ~pressed;
    sense.out_below_uvp       = limiting;
    sense.input_path_limiting = limiting;
    sense.bat_above_precond   = bat_mv >= 13'h0BB8;
    sense.bat_at_term         = bat_mv >= 13'h1068;
    // Charge current tapers off only once the cell sits at the termination voltage.
    sense.chg_below_eoc       = taper & (bat_mv >= 13'h1068);
    sense.bat_below_recharge  = bat_mv < 13'h0FA0;
    sense.bat_above_level     = {bat_mv >= 13'h0FA0, bat_mv >= 13'h0EA6,
                                 bat_mv >= 13'h0E10, bat_mv >= 13'h0D16};
  end
endmodule : bpm_partner

// File: sim/battery_pack_mode_charge_ctrl_bench.sv
// Self-checking bench of the mode and charge controller.
`timescale 1ns/10ps
module battery_pack_mode_charge_ctrl_bench import bpm_pkg::*;;
  logic        sys_clk, rst, hsel, hwrite, hresp, supply_on, store_sel;
  logic        pressed, overload, taper, flash_on;
  wire logic   hready;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans, shift;
  logic [2:0]  hsize;
  logic [12:0] bat_mv;
  logic [3:0]  leds;
  bpm_sense_t  sense;
  bpm_switch_t switches;
  bpm_cur_t    cur;
  int          mismatches = 0, checked = 0, ticks = 0, highs;

  // Boost thresholds and hiccup time keep their full counts, so the flashlight hold must outlast the boost thresholds.
  bpm_ctrl #(.TICK_CYCLES(4), .TRAN_TICKS(5), .PB_FLASH_TK(110), .LED_SHOW_TK(6),
    .LED_BLINK_TK(2)) dut (
    .sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .sense(sense),
    .switches(switches), .charge_current_set(cur), .level_threshold_shift(shift),
    .level_indicator_first(leds[0]), .level_indicator_second(leds[1]),
    .level_indicator_third(leds[2]), .level_indicator_fourth(leds[3]),
    .flashlight_on(flash_on));

  bpm_partner model (.supply_on(supply_on), .store_sel(store_sel), .pressed(pressed),
    .overload(overload), .taper(taper), .bat_mv(bat_mv), .switches(switches),
    .sense(sense));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic close_out;
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch time %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Outputs are looked at on the falling edge, away from the launching edge.
  task automatic at(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : at

  // One single AHB-Lite word transfer; waits on hready at both phases.
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rdv);
    @(posedge sys_clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h000000, a};
    hwrite <= wr;
    @(posedge sys_clk);
    while (hready !== 1'b1) @(posedge sys_clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge sys_clk);
    while (hready !== 1'b1) @(posedge sys_clk);
    rdv = hrdata;
  endtask : ahb

  function automatic logic [3:0] exp_leds(input logic [12:0] mv);
    return {mv >= 13'h0FA0, mv >= 13'h0EA6, mv >= 13'h0E10, mv >= 13'h0D16};
  endfunction : exp_leds

  always @(posedge sys_clk) begin
    ticks <= ticks + 1;
    if (ticks == 20000) begin
      mismatches++;
      close_out();
    end
  end

  initial begin
    void'($urandom(32'hB62DF6BA));
    {rst, hsel, hwrite, supply_on, pressed, overload, taper} = 7'h40;
    {haddr, hwdata, htrans, hsize} = {64'h0, 2'h0, 3'h2};
    store_sel = 1'b1;
    bat_mv    = 13'h0AF0;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    at(1);
    check(switches, 4'h0);
    check({cur, shift, leds, flash_on}, 9'h000);
    ahb(1'b0, REG_STATUS, 32'h0, rd);
    check(rd, 32'h0);
    check(hresp, 1'b0);
    ahb(1'b0, 8'h08, 32'h0, rd);
    check(rd, 32'h0);
    @(posedge sys_clk) supply_on <= 1'b1;
    at(12);
    check(cur, BPM_CUR_PRE);
    check(switches.input_path_switch, 1'b1);
    check(shift, SHIFT_CHARGE);
    ahb(1'b0, REG_STATUS, 32'h0, rd);
    check(rd[6:4], 3'h1);
    @(posedge sys_clk) bat_mv <= 13'h0DAC;
    at(8);
    check(cur, BPM_CUR_FULL);
    highs = 0;
    repeat (32) begin
      @(negedge sys_clk);
      highs += leds[1];
    end
    check(highs, 16);
    check(leds[0], 1'b1);
    // Hiccup: the input switch drops, stays off and returns on its own.
    @(posedge sys_clk) overload <= 1'b1;
    at(8);
    check(switches.input_path_switch, 1'b0);
    @(posedge sys_clk) overload <= 1'b0;
    at(4);
    check(switches.input_path_switch, 1'b0);
    at(8000);
    check(switches.input_path_switch, 1'b1);
    @(posedge sys_clk) bat_mv <= 13'h1068;
    at(8);
    check(cur, BPM_CUR_CV);
    @(posedge sys_clk) taper <= 1'b1;
    at(8);
    check(cur, BPM_CUR_OFF);
    check(leds, 4'hF);
    @(posedge sys_clk) {taper, bat_mv} <= {1'b0, 13'h0F3C};
    at(8);
    check(cur, BPM_CUR_FULL);
    @(posedge sys_clk) {supply_on, store_sel} <= 2'h0;
    at(8);
    check(switches, 4'h0);
    at(30);
    // A press shorter than the boost threshold must not start boost.
    @(posedge sys_clk) pressed <= 1'b1;
    at(6);
    @(posedge sys_clk) pressed <= 1'b0;
    at(10);
    check(switches, 4'h0);
    @(posedge sys_clk) pressed <= 1'b1;
    at(420);
    check(switches, 4'h7);
    check(shift, SHIFT_DISCHG);
    @(posedge sys_clk) {pressed, supply_on, store_sel} <= 3'h3;
    at(8);
    check(switches, 4'h0);
    at(30);
    check(switches.input_path_switch, 1'b1);
    @(posedge sys_clk) supply_on <= 1'b0;
    at(40);
    check(switches, 4'h0);
    check(shift, SHIFT_NONE);
    ahb(1'b1, REG_CTRL, 32'h1, rd);
    ahb(1'b0, REG_CTRL, 32'h0, rd);
    check(rd, 32'h1);
    highs = 1;
    repeat (2) begin
      @(posedge sys_clk) pressed <= 1'b1;
      at(460);
      check(flash_on, highs[0]);
      highs = highs ^ 1;
      @(posedge sys_clk) pressed <= 1'b0;
      at(4);
    end
    repeat (6) begin
      @(posedge sys_clk) bat_mv <= 13'($urandom_range(32'h10CB, 32'h0D16));
      at(4);
      @(posedge sys_clk) pressed <= 1'b1;
      at(140);
      check(leds, exp_leds(bat_mv));
      @(posedge sys_clk) pressed <= 1'b0;
      at(4);
    end
    at(40);
    check(leds, 4'h0);
    close_out();
  end
endmodule : battery_pack_mode_charge_ctrl_bench
